// file: verilog/tbr_defines.svh
// register offsets, field positions, codes and sizes of the block-read engine
`ifndef TBR_DEFINES_SVH
`define TBR_DEFINES_SVH
`define TBR_CMD_READ 8'h02
`define TBR_OFS_CMD 12'h000
`define TBR_OFS_RESULT 12'h004
`define TBR_OFS_PARAM0 12'h008
`define TBR_OFS_PARAM1 12'h00c
`define TBR_OFS_PARAM2 12'h010
`define TBR_OFS_STATUS 12'h014
`define TBR_OFS_IRQ_STAT 12'h018
`define TBR_OFS_IRQ_MASK 12'h01c
`define TBR_OFS_BUF 12'h100
`define TBR_BUF_BYTES 13'h100
`define TBR_BLK_BYTES 8'h10
`define TBR_KEY_MAX 6'h27
`define TBR_KEYSEL_B 7
`define TBR_KEYSEL_ARG 6
`define TBR_RES_OK 8'h00
`define TBR_RES_AUTH 8'h01
`define TBR_RES_READ 8'h02
`define TBR_RES_PARAM 8'h03
`define TBR_IRQ_DONE 0
`define TBR_IRQ_ERR 1
`define TBR_RESP_OKAY 2'h0
`define TBR_RESP_SLVERR 2'h2
`endif

// file: verilog/tbr_pkg.sv
// types shared by the block-read engine
package tbr_pkg;
    typedef enum logic [2:0] {
        TBR_IDLE = 3'b000,
        TBR_CHECK = 3'b001,
        TBR_AUTH = 3'b010,
        TBR_RD = 3'b011,
        TBR_DONE = 3'b100
    } tbr_state_e;
    typedef logic [11:0] tbr_addr_t;
endpackage

// file: verilog/tbr_reg_if.sv
// register access strobes between bus slave and register file
`timescale 1ns/1ps
interface tbr_reg_if;
    logic wr_en;
    tbr_pkg::tbr_addr_t wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    tbr_pkg::tbr_addr_t rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface

// file: verilog/tbr_axil.sv
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`include "tbr_defines.svh"
module tbr_axil (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    // write channels
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register file side
    tbr_reg_if.slv r
);
    logic aw_got_reg, w_got_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_have, w_have;

    assign awready = aclken & ~aw_got_reg & ~bvalid;
    assign wready = aclken & ~w_got_reg & ~bvalid;
    assign arready = aclken & ~rvalid;
    assign aw_have = aw_got_reg | (awvalid & awready);
    assign w_have = w_got_reg | (wvalid & wready);
    assign r.wr_en = aclken & aw_have & w_have & ~bvalid;
    assign r.wr_addr = aw_got_reg ? aw_addr_reg : awaddr;
    assign r.wr_data = w_got_reg ? w_data_reg : wdata;
    assign r.wr_strb = w_got_reg ? w_strb_reg : wstrb;
    assign r.rd_en = arvalid & arready;
    assign r.rd_addr = araddr;

    // address and data may arrive in either order; each is parked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (r.wr_en) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `TBR_RESP_OKAY;
        end else if (aclken) begin
            if (r.wr_en) begin
                bvalid <= 1'b1;
                bresp <= r.wr_err ? `TBR_RESP_SLVERR : `TBR_RESP_OKAY;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `TBR_RESP_OKAY;
        end else if (aclken) begin
            if (r.rd_en) begin
                rvalid <= 1'b1;
                rdata <= r.rd_data;
                rresp <= r.rd_err ? `TBR_RESP_SLVERR : `TBR_RESP_OKAY;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: verilog/tbr_top.sv
// block-read command engine with register file, data buffer and interrupt
// Summary of operation
// - command code 0x02 starts the block read
// - selector bit 7 picks key B, else A
// - selector bit 6 takes key from arguments
// - argument key is least significant byte first
// - authenticate starting sector before any read
// - failed authentication posts error and stops
// - read first block, continue while count remains
// - new sector is authenticated with same key
// - success fills buffer contiguously, posts no error
// - failed block read posts read error
// - selector low six bits index key 0-39
// - result register updated after every started read command; other command codes leave it unchanged
`timescale 1ns/1ps
`include "tbr_defines.svh"
module tbr_top (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    // axi4-lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // interrupt
    output logic irq,
    // stored key lookup
    output logic [5:0] stored_key_idx,
    input wire logic [47:0] stored_key,
    // tag engine
    output logic tag_auth_req,
    output logic tag_key_b,
    output logic [47:0] tag_key,
    output logic [7:0] tag_block,
    input wire logic tag_auth_done,
    input wire logic tag_auth_ok,
    output logic tag_rd_req,
    input wire logic tag_rd_done,
    input wire logic tag_rd_ok,
    input wire logic [127:0] tag_rd_data
);
    // ********************
    // decoding helpers
    // ********************
    function automatic logic addr_ok(input tbr_pkg::tbr_addr_t a);
        addr_ok = (a >= `TBR_OFS_BUF && a < `TBR_OFS_BUF + 12'h100) ||
                  (a <= `TBR_OFS_IRQ_MASK + 12'h003);
    endfunction

    function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
    endfunction

    // small sectors of four blocks, then sectors of sixteen from block 128
    function automatic logic [5:0] sector_of(input logic [7:0] b);
        sector_of = b[7] ? (6'h20 | {3'h0, b[6:4]}) : {1'b0, b[6:2]};
    endfunction

    tbr_reg_if r ();

    tbr_axil u_axil (
        .aclk(aclk), .aresetn(aresetn), .aclken(aclken),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .r(r)
    );

    // ********************
    // registers
    // ********************
    tbr_pkg::tbr_state_e state_reg;
    logic [7:0] cmd_reg, result_reg;
    logic [31:0] p0_reg, p1_reg;
    logic [15:0] p2_reg;
    logic [1:0] irq_stat_reg, irq_mask_reg;
    logic [7:0] blk_reg, left_reg, ptr_reg;
    logic [5:0] sect_reg;
    logic sect_vld_reg;
    logic [7:0] buf_mem [0:255];
    logic [7:0] cnt, off, ksel;
    logic busy, start, bad, sec_chg, done_ev, err_ev;
    logic [7:0] res_done;

    assign cnt = p0_reg[15:8];
    assign off = p0_reg[23:16];
    assign ksel = p0_reg[31:24];
    assign busy = state_reg != tbr_pkg::TBR_IDLE;
    assign r.wr_err = !addr_ok(r.wr_addr);
    assign r.rd_err = !addr_ok(r.rd_addr);
    assign start = aclken && r.wr_en && !busy && r.wr_addr == `TBR_OFS_CMD &&
                   r.wr_strb[0] && r.wr_data[7:0] == `TBR_CMD_READ;
    assign bad = cnt == 8'h00 ||
                 ({5'h00, off} + {1'b0, cnt, 4'h0} > `TBR_BUF_BYTES) ||
                 (!ksel[`TBR_KEYSEL_ARG] && ksel[5:0] > `TBR_KEY_MAX);
    assign sec_chg = sector_of(8'(blk_reg + 8'h01)) != sect_reg;
    assign stored_key_idx = ksel[5:0];
    assign tag_auth_req = state_reg == tbr_pkg::TBR_AUTH;
    assign tag_rd_req = state_reg == tbr_pkg::TBR_RD;
    assign done_ev = aclken && state_reg == tbr_pkg::TBR_DONE;
    assign err_ev = done_ev && result_reg != `TBR_RES_OK;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // argument registers are write-protected while a command runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_reg <= 8'h00;
            p0_reg <= 32'h0000_0000;
            p1_reg <= 32'h0000_0000;
            p2_reg <= 16'h0000;
            irq_mask_reg <= 2'h0;
        end else if (aclken && r.wr_en && !busy) begin
            unique case (r.wr_addr)
                `TBR_OFS_CMD: cmd_reg <= r.wr_strb[0] ? r.wr_data[7:0] : cmd_reg;
                `TBR_OFS_PARAM0: p0_reg <= wmask(p0_reg, r.wr_data, r.wr_strb);
                `TBR_OFS_PARAM1: p1_reg <= wmask(p1_reg, r.wr_data, r.wr_strb);
                `TBR_OFS_PARAM2: p2_reg <= 16'(wmask({16'h0000, p2_reg}, r.wr_data, r.wr_strb));
                `TBR_OFS_IRQ_MASK: irq_mask_reg <= r.wr_strb[0] ? r.wr_data[1:0] : irq_mask_reg;
                default: ;
            endcase
        end
    end

    // sticky events: a set in the same cycle as a clear wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 2'h0;
        end else if (aclken) begin
            irq_stat_reg <= (irq_stat_reg &
                ~((r.wr_en && r.wr_addr == `TBR_OFS_IRQ_STAT && r.wr_strb[0]) ?
                  r.wr_data[1:0] : 2'h0)) | {err_ev, done_ev};
        end
    end

    always_comb begin
        r.rd_data = 32'h0000_0000;
        if (!r.rd_err && r.rd_addr >= `TBR_OFS_BUF) begin
            r.rd_data = {buf_mem[{r.rd_addr[7:2], 2'h3}], buf_mem[{r.rd_addr[7:2], 2'h2}],
                         buf_mem[{r.rd_addr[7:2], 2'h1}], buf_mem[{r.rd_addr[7:2], 2'h0}]};
        end else begin
            unique case ({r.rd_addr[11:2], 2'h0})
                `TBR_OFS_CMD: r.rd_data = {24'h000000, cmd_reg};
                `TBR_OFS_RESULT: r.rd_data = {24'h000000, result_reg};
                `TBR_OFS_PARAM0: r.rd_data = p0_reg;
                `TBR_OFS_PARAM1: r.rd_data = p1_reg;
                `TBR_OFS_PARAM2: r.rd_data = {16'h0000, p2_reg};
                `TBR_OFS_STATUS: r.rd_data = {24'h000000, left_reg[6:0], busy};
                `TBR_OFS_IRQ_STAT: r.rd_data = {30'h0, irq_stat_reg};
                `TBR_OFS_IRQ_MASK: r.rd_data = {30'h0, irq_mask_reg};
                default: r.rd_data = 32'h0000_0000;
            endcase
        end
    end

    // ********************
    // command sequencer
    // ********************
    always_comb begin
        res_done = result_reg;
        unique case (state_reg)
            tbr_pkg::TBR_CHECK: res_done = `TBR_RES_PARAM;
            tbr_pkg::TBR_AUTH: res_done = `TBR_RES_AUTH;
            tbr_pkg::TBR_RD: res_done = tag_rd_ok ? `TBR_RES_OK : `TBR_RES_READ;
            default: res_done = result_reg;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= tbr_pkg::TBR_IDLE;
            result_reg <= `TBR_RES_OK;
        end else if (aclken) begin
            unique case (state_reg)
                tbr_pkg::TBR_IDLE: if (start) begin
                    state_reg <= tbr_pkg::TBR_CHECK;
                end
                tbr_pkg::TBR_CHECK: if (bad) begin
                    state_reg <= tbr_pkg::TBR_DONE;
                    result_reg <= res_done;
                end else begin
                    state_reg <= tbr_pkg::TBR_AUTH;
                end
                tbr_pkg::TBR_AUTH: if (tag_auth_done) begin
                    if (tag_auth_ok) begin
                        state_reg <= tbr_pkg::TBR_RD;
                    end else begin
                        state_reg <= tbr_pkg::TBR_DONE;
                        result_reg <= res_done;
                    end
                end
                tbr_pkg::TBR_RD: if (tag_rd_done) begin
                    if (!tag_rd_ok || left_reg == 8'h01) begin
                        state_reg <= tbr_pkg::TBR_DONE;
                        result_reg <= res_done;
                    end else if (sec_chg) begin
                        state_reg <= tbr_pkg::TBR_AUTH;
                    end
                end
                tbr_pkg::TBR_DONE: state_reg <= tbr_pkg::TBR_IDLE;
                default: state_reg <= tbr_pkg::TBR_IDLE;
            endcase
        end
    end

    // block, count and buffer pointer advance one block at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blk_reg <= 8'h00;
            left_reg <= 8'h00;
            ptr_reg <= 8'h00;
            sect_reg <= 6'h00;
            sect_vld_reg <= 1'b0;
            tag_key <= 48'h0;
            tag_key_b <= 1'b0;
        end else if (aclken) begin
            if (state_reg == tbr_pkg::TBR_CHECK) begin
                blk_reg <= p0_reg[7:0];
                left_reg <= cnt;
                ptr_reg <= off;
                sect_vld_reg <= 1'b0;
                tag_key_b <= ksel[`TBR_KEYSEL_B];
                tag_key <= ksel[`TBR_KEYSEL_ARG] ? {p2_reg, p1_reg} : stored_key;
            end
            if (tag_auth_req && tag_auth_done && tag_auth_ok) begin
                sect_reg <= sector_of(blk_reg);
                sect_vld_reg <= 1'b1;
            end
            if (tag_rd_req && tag_rd_done && tag_rd_ok && left_reg != 8'h01) begin
                blk_reg <= 8'(blk_reg + 8'h01);
                left_reg <= 8'(left_reg - 8'h01);
                ptr_reg <= 8'(ptr_reg + `TBR_BLK_BYTES);
            end
        end
    end

    assign tag_block = blk_reg;

    // data buffer: the tag engine wins over a host write in the same cycle
    always_ff @(posedge aclk) begin
        if (aclken) begin
            if (tag_rd_req && tag_rd_done && tag_rd_ok) begin
                for (int i = 0; i < 16; i++) begin
                    buf_mem[8'(ptr_reg + 8'(i))] <= tag_rd_data[8*i +: 8];
                end
            end else if (r.wr_en && !r.wr_err && r.wr_addr >= `TBR_OFS_BUF) begin
                for (int i = 0; i < 4; i++) begin
                    if (r.wr_strb[i]) begin
                        buf_mem[{r.wr_addr[7:2], 2'(i)}] <= r.wr_data[8*i +: 8];
                    end
                end
            end
        end
    end

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_start;
        start |=> state_reg == tbr_pkg::TBR_CHECK;
    endproperty
    a_start: assert property (p_start) else $error("read command not started");
    property p_key_b;
        tag_auth_req |-> tag_key_b == ksel[7];
    endproperty
    a_key_b: assert property (p_key_b) else $error("wrong key type");
    property p_key_arg;
        tag_auth_req && ksel[6] |-> tag_key[7:0] == p1_reg[7:0] && tag_key[47:40] == p2_reg[15:8];
    endproperty
    a_key_arg: assert property (p_key_arg) else $error("argument key misordered");
    property p_auth_before_read;
        tag_rd_req |-> sect_vld_reg && sect_reg == sector_of(tag_block);
    endproperty
    a_auth_before_read: assert property (p_auth_before_read) else $error("no auth");
    property p_auth_fail;
        aclken && tag_auth_req && tag_auth_done && !tag_auth_ok |=>
            state_reg == tbr_pkg::TBR_DONE && result_reg == `TBR_RES_AUTH;
    endproperty
    a_auth_fail: assert property (p_auth_fail) else $error("auth failure not posted");
    property p_next_block;
        aclken && tag_rd_req && tag_rd_done && tag_rd_ok && left_reg > 8'h01 |=>
            tag_block == 8'($past(tag_block) + 8'h01) && left_reg == 8'($past(left_reg) - 8'h01);
    endproperty
    a_next_block: assert property (p_next_block) else $error("block order broken");
    property p_last_ok;
        aclken && tag_rd_req && tag_rd_done && tag_rd_ok && left_reg == 8'h01 |=>
            state_reg == tbr_pkg::TBR_DONE && result_reg == `TBR_RES_OK ##1 irq_stat_reg[0];
    endproperty
    a_last_ok: assert property (p_last_ok) else $error("success not posted");
    property p_rd_fail;
        aclken && tag_rd_req && tag_rd_done && !tag_rd_ok |=> result_reg == `TBR_RES_READ;
    endproperty
    a_rd_fail: assert property (p_rd_fail) else $error("read failure not posted");
    property p_refuse;
        aclken && state_reg == tbr_pkg::TBR_CHECK && bad |=>
            state_reg == tbr_pkg::TBR_DONE && result_reg == `TBR_RES_PARAM;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad arguments accepted");
    property p_idx;
        aclken && state_reg == tbr_pkg::TBR_CHECK && !ksel[6] && ksel[5:0] > 6'h27 |=>
            state_reg == tbr_pkg::TBR_DONE;
    endproperty
    a_idx: assert property (p_idx) else $error("key index out of range used");
    property p_finish;
        state_reg == tbr_pkg::TBR_DONE && aclken |=> irq_stat_reg[0] && !busy;
    endproperty
    a_finish: assert property (p_finish) else $error("completion not flagged");

    c_multi: cover property (tag_rd_req && tag_rd_done && tag_rd_ok && left_reg == 8'h02);
    c_reauth: cover property (tag_rd_req && tag_rd_done && tag_rd_ok && sec_chg && left_reg > 1);
    c_auth_fail: cover property (tag_auth_req && tag_auth_done && !tag_auth_ok);
    c_refuse: cover property (state_reg == tbr_pkg::TBR_CHECK && bad);
endmodule

// file: tb/tbr_tag_model.sv
// behavioural tag in the antenna field answering the block-read engine
`timescale 1ns/1ps
module tbr_tag_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // tag engine
    input wire logic tag_auth_req,
    input wire logic tag_key_b,
    input wire logic [47:0] tag_key,
    input wire logic [7:0] tag_block,
    input wire logic tag_rd_req,
    output logic tag_auth_done,
    output logic tag_auth_ok,
    output logic tag_rd_done,
    output logic tag_rd_ok,
    output logic [127:0] tag_rd_data,
    // behaviour set by the bench
    input wire logic [47:0] good_key,
    input wire logic good_key_b,
    input wire logic [8:0] bad_blk,
    input wire logic [3:0] lag
);
    logic [3:0] cnt_reg;
    logic [7:0] sec_reg;
    logic sec_v_reg;
    function automatic logic [7:0] sector(input logic [7:0] b);
        sector = (b < 8'h80) ? (b >> 2) : (8'h20 + ((b - 8'h80) >> 4));
    endfunction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 4'h0;
            sec_v_reg <= 1'b0;
            tag_auth_done <= 1'b0;
            tag_rd_done <= 1'b0;
            tag_auth_ok <= 1'b0;
            tag_rd_ok <= 1'b0;
            tag_rd_data <= '0;
        end else begin
            tag_auth_done <= 1'b0;
            tag_rd_done <= 1'b0;
            // released data lines do not keep the last value
            tag_rd_data <= ~tag_rd_data;
            if ((tag_auth_req || tag_rd_req) && !tag_auth_done && !tag_rd_done) begin
                if (cnt_reg != lag) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end else if (tag_auth_req) begin
                    cnt_reg <= 4'h0;
                    tag_auth_done <= 1'b1;
                    tag_auth_ok <= (tag_key === good_key) && (tag_key_b === good_key_b);
                    sec_v_reg <= (tag_key === good_key) && (tag_key_b === good_key_b);
                    sec_reg <= sector(tag_block);
                end else begin
                    cnt_reg <= 4'h0;
                    tag_rd_done <= 1'b1;
                    // a block outside the authenticated sector is not given out
                    tag_rd_ok <= sec_v_reg && (sec_reg == sector(tag_block))
                        && ({1'b0, tag_block} != bad_blk);
                    for (int i = 0; i < 16; i++) begin
                        tag_rd_data[8*i +: 8] <= tag_block + 8'(i);
                    end
                end
            end
        end
    end
endmodule

// file: tb/tbr_top_tb.sv
// self-checking bench of the block-read engine
`timescale 1ns/1ps
`include "tbr_defines.svh"
module tbr_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, aclken = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, tag_auth_req, tag_key_b, tag_rd_req;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] stored_key_idx;
    logic [47:0] stored_key, tag_key, good_key = 48'h0;
    logic [7:0] tag_block;
    logic tag_auth_done, tag_auth_ok, tag_rd_done, tag_rd_ok, good_key_b = 1'b0;
    logic [127:0] tag_rd_data;
    logic [8:0] bad_blk = 9'h1ff;
    logic [3:0] lag = 4'h3;
    int miscompares = 0, n_checks = 0, cyc = 0, n_auth = 0, n_rd = 0;
    always #5 aclk = ~aclk;
    assign stored_key = {36'ha5a5a5a5a, 6'h00, stored_key_idx};
    tbr_top i_tbr_top (.aclk(aclk), .aresetn(aresetn), .aclken(aclken), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq), .stored_key_idx(stored_key_idx), .stored_key(stored_key),
        .tag_auth_req(tag_auth_req), .tag_key_b(tag_key_b), .tag_key(tag_key),
        .tag_block(tag_block), .tag_auth_done(tag_auth_done), .tag_auth_ok(tag_auth_ok),
        .tag_rd_req(tag_rd_req), .tag_rd_done(tag_rd_done), .tag_rd_ok(tag_rd_ok),
        .tag_rd_data(tag_rd_data));
    tbr_tag_model i_tbr_tag_model (.aclk(aclk), .aresetn(aresetn), .tag_auth_req(tag_auth_req),
        .tag_key_b(tag_key_b), .tag_key(tag_key), .tag_block(tag_block),
        .tag_rd_req(tag_rd_req), .tag_auth_done(tag_auth_done), .tag_auth_ok(tag_auth_ok),
        .tag_rd_done(tag_rd_done), .tag_rd_ok(tag_rd_ok), .tag_rd_data(tag_rd_data),
        .good_key(good_key), .good_key_b(good_key_b), .bad_blk(bad_blk), .lag(lag));
    // ********************
    // tasks
    // ********************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        n_auth += (tag_auth_req && tag_auth_done) ? 1 : 0;
        n_rd += (tag_rd_req && tag_rd_done) ? 1 : 0;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= {a, 1'b1, d, 4'hf, 1'b1, 1'b1};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] ew(input logic [7:0] b);
        ew = {b + 8'h3, b + 8'h2, b + 8'h1, b};
    endfunction
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d, e);
    endtask
    // one command, its result and tag traffic
    task automatic run(input logic [31:0] p0, input logic [47:0] key, input logic [7:0] res,
                       input int na, input int nr);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        axw(`TBR_OFS_IRQ_STAT, 32'h3, r);
        axw(`TBR_OFS_PARAM1, key[31:0], r);
        axw(`TBR_OFS_PARAM2, {16'h0, key[47:32]}, r);
        axw(`TBR_OFS_PARAM0, p0, r);
        n_auth = 0;
        n_rd = 0;
        axw(`TBR_OFS_CMD, {24'h0, `TBR_CMD_READ}, r);
        n = 0;
        do begin axr(`TBR_OFS_STATUS, d, r); n++; end while (d[0] !== 1'b0 && n < 300);
        axr(`TBR_OFS_RESULT, d, r);
        chk(d, {24'h0, res});
        chk(32'(n_auth), 32'(na));
        chk(32'(n_rd), 32'(nr));
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_reset_and_bus();
        logic [31:0] d;
        logic [1:0] r;
        rdchk(`TBR_OFS_RESULT, 32'h0);
        rdchk(`TBR_OFS_STATUS, 32'h0);
        axw(12'h020, 32'hffff_ffff, r);
        chk({30'h0, r}, {30'h0, `TBR_RESP_SLVERR});
        axr(12'h020, d, r);
        chk({d[29:0], r}, {30'h0, `TBR_RESP_SLVERR});
        axw(`TBR_OFS_CMD, 32'h1, r);
        repeat (20) @(posedge aclk);
        chk(32'(n_auth), 32'h0);
    endtask
    task automatic t_reads();
        logic [1:0] r;
        good_key = 48'h6655_4433_2211;
        good_key_b = 1'b1;
        axw(`TBR_OFS_IRQ_MASK, 32'h3, r);
        run({8'hc0, 8'h10, 8'h03, 8'h02}, good_key, `TBR_RES_OK, 2, 3);
        rdchk(`TBR_OFS_BUF + 12'h010, ew(8'h02));
        rdchk(`TBR_OFS_BUF + 12'h03c, ew(8'h10));
        chk({31'h0, irq}, 32'h1);
        axw(`TBR_OFS_IRQ_STAT, 32'h1, r);
        chk({31'h0, irq}, 32'h0);
        // stored key 5 as key a, buffer filled to its end
        good_key_b = 1'b0;
        lag = 4'h0;
        good_key = {36'ha5a5a5a5a, 6'h00, 6'h05};
        run({8'h05, 8'he0, 8'h02, 8'hfe}, 48'h0, `TBR_RES_OK, 1, 2);
        rdchk(`TBR_OFS_BUF + 12'h0e0, ew(8'hfe));
        rdchk(`TBR_OFS_BUF + 12'h0f0, ew(8'hff));
    endtask
    task automatic t_errors();
        logic [1:0] r;
        logic [31:0] bad [3];
        bad = '{{8'h40, 8'h40, 8'h00, 8'h08}, {8'h40, 8'hf0, 8'h02, 8'h08},
                {8'h28, 8'h40, 8'h01, 8'h08}};
        lag = 4'h5;
        axw(`TBR_OFS_IRQ_MASK, 32'h0, r);
        axw(`TBR_OFS_BUF + 12'h040, 32'hdead_beef, r);
        good_key_b = 1'b1;
        run({8'h40, 8'h40, 8'h01, 8'h08}, good_key, `TBR_RES_AUTH, 1, 0);
        rdchk(`TBR_OFS_BUF + 12'h040, 32'hdead_beef);
        rdchk(`TBR_OFS_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        good_key_b = 1'b0;
        bad_blk = 9'h009;
        run({8'h40, 8'h80, 8'h02, 8'h08}, good_key, `TBR_RES_READ, 1, 2);
        rdchk(`TBR_OFS_BUF + 12'h080, ew(8'h08));
        for (int i = 0; i < 3; i++) begin
            run(bad[i], good_key, `TBR_RES_PARAM, 0, 0);
        end
        axw(12'h240, 32'h0, r);
        rdchk(`TBR_OFS_BUF + 12'h040, 32'hdead_beef);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_and_bus();
        t_reads();
        t_errors();
        tally_and_finish();
    end
endmodule
